// >>> core/escs_cfg.svh
// constants of the external sample clock select block
// assumes a 250 MHz system clock and word-indexed register offsets
`ifndef ESCS_CFG_SVH
`define ESCS_CFG_SVH

// register indices, byte address is four times the index
`define ESCS_IDX_W           22
`define ESCS_IDX_DIVIDER     22'h004e48
`define ESCS_IDX_SOURCE      22'h004e84
`define ESCS_IDX_TERM        22'h004e98
`define ESCS_IDX_RANGE       22'h004ea2
`define ESCS_IDX_LOWSPEED    22'h0480bc
`define ESCS_IDX_CTRL        22'h004e00
`define ESCS_IDX_STATUS      22'h004e01

// field layout
`define ESCS_DIV_W           11
`define ESCS_RANGE_W         6
`define ESCS_ST_RUNNING      0
`define ESCS_ST_EXTACTIVE    1
`define ESCS_ST_CLKLOST      2
`define ESCS_ST_LOWSPEED     3
`define ESCS_ST_DIV_LSB      16

// speed range codes
`define ESCS_RANGE_SINGLE    6'h00
`define ESCS_RANGE_BURST_S   6'h04
`define ESCS_RANGE_BURST_M   6'h08
`define ESCS_RANGE_BURST_L   6'h10
`define ESCS_RANGE_XL        6'h20

// reset values
`define ESCS_RST_DIVIDER     11'h001
`define ESCS_RST_RANGE       6'h00

// timing: lowest normal external rate is 1 kHz, one period in microseconds
`define ESCS_MIN_EXT_PERIOD_US 1000
`define ESCS_CLK_PERIOD_PS     4000
`define ESCS_LOSS_CYCLES       ((`ESCS_MIN_EXT_PERIOD_US * 1000000) / `ESCS_CLK_PERIOD_PS)

// bus answers
`define ESCS_RESP_OKAY       2'h0
`define ESCS_RESP_SLVERR     2'h2

`endif

// >>> core/escs_pkg.sv
// types of the external sample clock select block
// assumes escs_cfg.svh for all numeric constants
`include "escs_cfg.svh"

package escs_pkg;

    // clock settings as used by one acquisition run
    typedef struct packed {
        logic                     extSel;
        logic                     lowSpeed;
        logic [`ESCS_RANGE_W-1:0] rangeCode;
        logic [`ESCS_DIV_W-1:0]   divisor;
    } escs_clk_cfg_type;

endpackage : escs_pkg

// >>> core/escs_top.sv
// external sample clock select: register slave, divider, source mux, clock watchdog
// assumes an AXI4-Lite master on clk and an external clock pin asynchronous to clk
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`include "escs_cfg.svh"

// How it works
// - a one in the source select register makes the external connector the sample clock source, zero the internal clock.
// - the termination register switches on the 50 Ohm load only while the connector is an input.
// - the range register holds only one of the five range codes, burst M being 8 and XL 32.
// - software picks the range code from the enabled channels and the mode.
// - the external clock is divided by one of the listed fixed factors to form the sample clock.
// - the low speed mode lets the external clock go down to DC.
// - the low speed mode is off after reset.
module escs_top
    import escs_pkg::*;
#(
    parameter int LOSS_CYCLES = `ESCS_LOSS_CYCLES
) (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rstn,
    // AXI4-Lite write address and data
    input  wire logic [23:0]                s_axi_awaddr,
    input  wire logic [2:0]                 s_axi_awprot,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    // AXI4-Lite read
    input  wire logic [23:0]                s_axi_araddr,
    input  wire logic [2:0]                 s_axi_arprot,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // clock connector and internal generator
    input  wire logic                       extClkIn,
    input  wire logic                       clkOutEn,
    input  wire logic                       intSampleTick,
    // to the sampling path and front end
    output logic                            sampleTick,
    output logic                            useExtClk,
    output logic                            termEn,
    output logic [`ESCS_RANGE_W-1:0]        rangeSel,
    output logic                            lowSpeedEn
);

    function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
                                               input logic [31:0] newV,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = oldV;
        for (int b = 0; b < 4; b++) begin
            res[8*b +: 8] = strb[b] ? newV[8*b +: 8] : oldV[8*b +: 8];
        end
        return res;
    endfunction : mergeBytes

    function automatic logic legalDivisor(input logic [31:0] v);
        return v inside {32'h1, 32'h2, 32'h4, 32'h8, 32'ha, 32'h10, 32'h14, 32'h28, 32'h32,
                         32'h50, 32'h64, 32'hc8, 32'h190, 32'h1f4, 32'h320, 32'h3e8, 32'h7d0};
    endfunction : legalDivisor

    function automatic logic legalRange(input logic [31:0] v);
        return (v == {26'h0, `ESCS_RANGE_SINGLE}) || (v == {26'h0, `ESCS_RANGE_BURST_S}) ||
               (v == {26'h0, `ESCS_RANGE_BURST_M}) || (v == {26'h0, `ESCS_RANGE_BURST_L}) ||
               (v == {26'h0, `ESCS_RANGE_XL});
    endfunction : legalRange

    logic                       awHeld_r, wHeld_r, bvalid_r, rvalid_r, wrFire, rdHit, wrHit;
    logic                       term_r, runReq_r, running_r, startPulse;
    logic                       extSync1_r, extSync2_r, extPrev_r, extEdge, divHit;
    logic                       sampleTick_r, termEn_r, clkLost_r;
    logic [`ESCS_IDX_W-1:0]     awIdx_r, arIdx;
    logic [31:0]                wData_r, rdata_r, rdVal, wrVal, oldVal, lossCnt_r;
    logic [3:0]                 wStrb_r;
    logic [1:0]                 bresp_r, rresp_r;
    logic [`ESCS_DIV_W-1:0]     divCnt_r;
    escs_clk_cfg_type           shadow_r, act_r;
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // register decode
    assign wrFire = awHeld_r && wHeld_r && !bvalid_r;
    assign arIdx  = s_axi_araddr[23:2];

    always_comb begin
        oldVal = 32'h0;
        wrHit  = 1'b1;
        unique case (awIdx_r)
            `ESCS_IDX_DIVIDER:  oldVal = {21'h0, shadow_r.divisor};
            `ESCS_IDX_SOURCE:   oldVal = {31'h0, shadow_r.extSel};
            `ESCS_IDX_TERM:     oldVal = {31'h0, term_r};
            `ESCS_IDX_RANGE:    oldVal = {26'h0, shadow_r.rangeCode};
            `ESCS_IDX_LOWSPEED: oldVal = {31'h0, shadow_r.lowSpeed};
            `ESCS_IDX_CTRL:     oldVal = {31'h0, runReq_r};
            `ESCS_IDX_STATUS:   oldVal = 32'h0;
            default:            wrHit  = 1'b0;
        endcase
        wrVal = mergeBytes(oldVal, wData_r, wStrb_r);
    end

    always_comb begin
        rdVal = 32'h0;
        rdHit = 1'b1;
        unique case (arIdx)
            `ESCS_IDX_DIVIDER:  rdVal = {21'h0, shadow_r.divisor};
            `ESCS_IDX_SOURCE:   rdVal = {31'h0, shadow_r.extSel};
            `ESCS_IDX_TERM:     rdVal = {31'h0, term_r};
            `ESCS_IDX_RANGE:    rdVal = {26'h0, shadow_r.rangeCode};
            `ESCS_IDX_LOWSPEED: rdVal = {31'h0, shadow_r.lowSpeed};
            `ESCS_IDX_CTRL:     rdVal = {31'h0, runReq_r};
            `ESCS_IDX_STATUS: begin
                rdVal[`ESCS_ST_RUNNING]   = running_r;
                rdVal[`ESCS_ST_EXTACTIVE] = running_r && act_r.extSel;
                rdVal[`ESCS_ST_CLKLOST]   = clkLost_r;
                rdVal[`ESCS_ST_LOWSPEED]  = act_r.lowSpeed;
                rdVal[`ESCS_ST_DIV_LSB +: `ESCS_DIV_W] = act_r.divisor;
            end
            default:            rdHit = 1'b0;
        endcase
    end

    // write channel: address and data taken in either order
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awHeld_r <= 1'b0;
            awIdx_r  <= '0;
            wHeld_r  <= 1'b0;
            wData_r  <= 32'h0;
            wStrb_r  <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r  <= `ESCS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awIdx_r  <= s_axi_awaddr[23:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_r <= 1'b0;
                wHeld_r  <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r  <= wrHit ? `ESCS_RESP_OKAY : `ESCS_RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // read channel
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0;
            rresp_r  <= `ESCS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rdVal;
            rresp_r  <= rdHit ? `ESCS_RESP_OKAY : `ESCS_RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_awready = !awHeld_r && !bvalid_r;
    assign s_axi_wready  = !wHeld_r && !bvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // software settings; illegal divisor or range codes are ignored
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            shadow_r.extSel    <= 1'b0;
            shadow_r.lowSpeed  <= 1'b0;
            shadow_r.rangeCode <= `ESCS_RST_RANGE;
            shadow_r.divisor   <= `ESCS_RST_DIVIDER;
            term_r             <= 1'b0;
            runReq_r           <= 1'b0;
        end else if (wrFire) begin
            unique case (awIdx_r)
                `ESCS_IDX_DIVIDER: begin
                    if (legalDivisor(wrVal)) begin
                        shadow_r.divisor <= wrVal[`ESCS_DIV_W-1:0];
                    end
                end
                `ESCS_IDX_SOURCE:   shadow_r.extSel <= wrVal[0];
                `ESCS_IDX_TERM:     term_r <= wrVal[0];
                `ESCS_IDX_RANGE: begin
                    if (legalRange(wrVal)) begin
                        shadow_r.rangeCode <= wrVal[`ESCS_RANGE_W-1:0];
                    end
                end
                `ESCS_IDX_LOWSPEED: shadow_r.lowSpeed <= wrVal[0];
                `ESCS_IDX_CTRL:     runReq_r <= wrVal[0];
                default: ;
            endcase
        end
    end

    // clock settings take effect only at a start
    assign startPulse = runReq_r && !running_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            running_r <= 1'b0;
            act_r     <= '{1'b0, 1'b0, `ESCS_RST_RANGE, `ESCS_RST_DIVIDER};
        end else begin
            running_r <= runReq_r;
            if (startPulse) begin
                act_r <= shadow_r;
            end
        end
    end

    // external clock pin into the clk domain
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            extSync1_r <= 1'b0;
            extSync2_r <= 1'b0;
            extPrev_r  <= 1'b0;
        end else begin
            extSync1_r <= extClkIn;
            extSync2_r <= extSync1_r;
            extPrev_r  <= extSync2_r;
        end
    end

    assign extEdge = extSync2_r && !extPrev_r;
    assign divHit  = extEdge && (divCnt_r == act_r.divisor - `ESCS_DIV_W'(1));

    // fixed divider on external edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divCnt_r <= '0;
        end else if (!running_r || !act_r.extSel) begin
            divCnt_r <= '0;
        end else if (divHit) begin
            divCnt_r <= '0;
        end else if (extEdge) begin
            divCnt_r <= divCnt_r + `ESCS_DIV_W'(1);
        end
    end

    // source mux and connector termination
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sampleTick_r <= 1'b0;
            termEn_r     <= 1'b0;
        end else begin
            sampleTick_r <= running_r && (act_r.extSel ? divHit : intSampleTick);
            termEn_r     <= term_r && !clkOutEn;
        end
    end

    // watchdog for a clock slower than the normal minimum; off in low speed mode
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            lossCnt_r <= 32'h0;
            clkLost_r <= 1'b0;
        end else if (startPulse || !running_r || !act_r.extSel || act_r.lowSpeed) begin
            lossCnt_r <= 32'h0;
            clkLost_r <= startPulse ? 1'b0 : clkLost_r;
        end else if (extEdge) begin
            lossCnt_r <= 32'h0;
        end else if (lossCnt_r >= 32'(LOSS_CYCLES - 1)) begin
            clkLost_r <= 1'b1;
        end else begin
            lossCnt_r <= lossCnt_r + 32'h1;
        end
    end

    assign sampleTick = sampleTick_r;
    assign useExtClk  = act_r.extSel;
    assign termEn     = termEn_r;
    assign rangeSel   = act_r.rangeCode;
    assign lowSpeedEn = act_r.lowSpeed;

    property p_srcMux;
        running_r |=> sampleTick == (act_r.extSel ? $past(divHit) : $past(intSampleTick));
    endproperty
    a_srcMux: assert property (p_srcMux) else $error("sample tick from wrong source");
    property p_term;
        termEn |-> !$past(clkOutEn) && $past(term_r);
    endproperty
    a_term: assert property (p_term) else $error("termination on while driving");
    property p_range;
        legalRange({26'h0, shadow_r.rangeCode}) && legalRange({26'h0, rangeSel});
    endproperty
    a_range: assert property (p_range) else $error("illegal range code held");
    property p_divLegal;
        legalDivisor({21'h0, shadow_r.divisor}) && legalDivisor({21'h0, act_r.divisor});
    endproperty
    a_divLegal: assert property (p_divLegal) else $error("illegal divisor held");
    property p_divSpacing;
        running_r && act_r.extSel && extEdge && !divHit |=> divCnt_r == $past(divCnt_r) + 11'h001;
    endproperty
    a_divSpacing: assert property (p_divSpacing) else $error("divider skipped an edge");
    property p_lowSpeed;
        running_r && act_r.lowSpeed && !startPulse |=> $stable(clkLost_r) && lossCnt_r == 32'h0;
    endproperty
    a_lowSpeed: assert property (p_lowSpeed) else $error("watchdog active at dc");
    property p_lowSpeedSet;
        $rose(shadow_r.lowSpeed) |-> $past(wrFire) && $past(awIdx_r) == `ESCS_IDX_LOWSPEED;
    endproperty
    a_lowSpeedSet: assert property (p_lowSpeedSet) else $error("low speed set unasked");
    property p_hold;
        running_r && $past(running_r) |-> $stable(act_r);
    endproperty
    a_hold: assert property (p_hold) else $error("settings changed while running");
    property p_start;
        $rose(running_r) |-> act_r == $past(shadow_r);
    endproperty
    a_start: assert property (p_start) else $error("settings not taken at start");

endmodule : escs_top

// >>> sim/escs_ext_clk_gen.sv
// model of the external clock source on the clock connector
// assumes the bench calls burst() for each frame of clock edges
module escs_ext_clk_gen #(
    parameter int MIN_HALF_NS = 167
) (
    // clock connector
    output logic extClk
);
    timeunit 1ns;
    timeprecision 1ps;

    // line rests low between frames
    initial extClk = 1'b0;

    task automatic burst(input int n, input int halfNs);
        int h;
        // never faster than the variant ceiling
        h = (halfNs < MIN_HALF_NS) ? MIN_HALF_NS : halfNs;
        repeat (n) begin
            #(h) extClk = 1'b1;
            #(h) extClk = 1'b0;
        end
    endtask : burst
endmodule : escs_ext_clk_gen

// >>> sim/external_sample_clock_select_bench.sv
// self-checking bench of the external sample clock select block
// assumes escs_top with an AXI4-Lite slave and the external clock model
`include "escs_cfg.svh"

module external_sample_clock_select_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         LOSS = 200;
    localparam logic [1:0] OK   = `ESCS_RESP_OKAY;
    localparam logic [1:0] ERR  = `ESCS_RESP_SLVERR;

    logic        clk, rstn, awValid, wValid, bReady, arValid, rReady, clkOutEn, intTick;
    logic [23:0] awAddr, arAddr;
    logic [31:0] wData, rData;
    logic        awReady, wReady, bValid, arReady, rValid, sampleTick, useExt, termEn;
    logic        lowSpeedEn, extClk;
    logic [1:0]  bResp, rResp;
    logic [5:0]  rangeSel;
    logic [33:0] rExp;
    logic [33:0] readQ[$];
    logic [1:0]  respQ[$];
    int          mismatches, checked, ticks;
    logic [31:0] lfsrState = 32'hbd7f5273;
    logic [5:0]  rangeCodes[5] = '{`ESCS_RANGE_SINGLE, `ESCS_RANGE_BURST_S,
                                   `ESCS_RANGE_BURST_M, `ESCS_RANGE_BURST_L, `ESCS_RANGE_XL};
    logic [10:0] divs[17] = '{11'h001, 11'h002, 11'h004, 11'h008, 11'h00a, 11'h010, 11'h014,
                              11'h028, 11'h032, 11'h050, 11'h064, 11'h0c8, 11'h190, 11'h1f4,
                              11'h320, 11'h3e8, 11'h7d0};

    escs_top #(.LOSS_CYCLES(LOSS)) dut (
        .clk(clk), .rstn(rstn),
        .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
        .s_axi_rready(rReady), .extClkIn(extClk), .clkOutEn(clkOutEn),
        .intSampleTick(intTick), .sampleTick(sampleTick), .useExtClk(useExt),
        .termEn(termEn), .rangeSel(rangeSel), .lowSpeedEn(lowSpeedEn)
    );
    escs_ext_clk_gen gen (.extClk(extClk));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // status word: divisor, then low speed, lost, external, running
    function automatic logic [31:0] st(input logic [10:0] dv, input logic [3:0] b);
        return {5'h00, dv, 12'h000, b};
    endfunction : st

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic test_done();
        $display("TB: checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic wr(input logic [21:0] idx, input logic [31:0] d, input logic [1:0] er);
        bit pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        respQ.push_back(er);
        @(posedge clk);
        awAddr  <= {idx, 2'b00};
        awValid <= 1'b1;
        wData   <= d;
        wValid  <= 1'b1;
        bReady  <= 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && awReady === 1'b1;
            tw = pw && wReady === 1'b1;
            @(posedge clk);
            if (ta) awValid <= 1'b0;
            if (tw) wValid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge clk); while (bValid !== 1'b1);
        @(posedge clk);
        bReady <= 1'b0;
    endtask : wr

    task automatic rd(input logic [21:0] idx, input logic [31:0] ed, input logic [1:0] er);
        readQ.push_back({er, ed});
        @(posedge clk);
        arAddr  <= {idx, 2'b00};
        arValid <= 1'b1;
        rReady  <= 1'b1;
        do @(negedge clk); while (arReady !== 1'b1);
        @(posedge clk);
        arValid <= 1'b0;
        do @(negedge clk); while (rValid !== 1'b1);
        @(posedge clk);
        rReady <= 1'b0;
    endtask : rd

    task automatic run(input logic v);
        wr(`ESCS_IDX_CTRL, {31'h0, v}, OK);
        repeat (2) @(posedge clk);
        @(negedge clk);
        ticks = 0;
    endtask : run

    // result watcher: oldest expectation against each answer
    always @(posedge clk) begin
        if (bValid === 1'b1 && bReady === 1'b1) begin
            chk({30'h0, bResp}, {30'h0, respQ.pop_front()});
        end
        if (rValid === 1'b1 && rReady === 1'b1) begin
            rExp = readQ.pop_front();
            chk(rData, rExp[31:0]);
            chk({30'h0, rResp}, {30'h0, rExp[33:32]});
        end
        if (sampleTick === 1'b1) ticks = ticks + 1;
    end

    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial begin
        {rstn, awValid, wValid, bReady, arValid, rReady, clkOutEn, intTick} = 8'h00;
        awAddr = 24'h000000;
        arAddr = 24'h000000;
        wData = 32'h00000000;
        mismatches = 0;
        checked = 0;
        ticks = 0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        rd(`ESCS_IDX_DIVIDER, 32'h00000001, OK);
        rd(`ESCS_IDX_SOURCE, 32'h00000000, OK);
        rd(`ESCS_IDX_TERM, 32'h00000000, OK);
        rd(`ESCS_IDX_LOWSPEED, 32'h00000000, OK);
        rd(22'h000001, 32'h00000000, ERR);
        wr(22'h000001, 32'h00000005, ERR);
        $display("TB: reset and map test done");
        foreach (rangeCodes[i]) begin
            wr(`ESCS_IDX_RANGE, {26'h0, rangeCodes[i]}, OK);
            rd(`ESCS_IDX_RANGE, {26'h0, rangeCodes[i]}, OK);
        end
        wr(`ESCS_IDX_RANGE, 32'h00000005, OK);
        rd(`ESCS_IDX_RANGE, 32'h00000020, OK);
        foreach (divs[i]) begin
            wr(`ESCS_IDX_DIVIDER, {21'h0, divs[i]}, OK);
            rd(`ESCS_IDX_DIVIDER, {21'h0, divs[i]}, OK);
        end
        wr(`ESCS_IDX_DIVIDER, 32'h00000003, OK);
        rd(`ESCS_IDX_DIVIDER, 32'h000007d0, OK);
        $display("TB: range and divider test done");
        wr(`ESCS_IDX_TERM, 32'h00000001, OK);
        repeat (3) @(posedge clk);
        chk({31'h0, termEn}, 32'h00000001);
        clkOutEn <= 1'b1;
        repeat (3) @(posedge clk);
        chk({31'h0, termEn}, 32'h00000000);
        clkOutEn <= 1'b0;
        $display("TB: termination test done");
        run(1'b1);
        repeat (12) begin
            lfsrState = lfsr(lfsrState);
            repeat (int'(lfsrState[2:0]) + 1) @(posedge clk);
            intTick <= 1'b1;
            @(posedge clk);
            intTick <= 1'b0;
        end
        repeat (4) @(posedge clk);
        chk(32'(ticks), 32'h0000000c);
        chk({31'h0, useExt}, 32'h00000000);
        run(1'b0);
        $display("TB: internal clock test done");
        wr(`ESCS_IDX_SOURCE, 32'h00000001, OK);
        wr(`ESCS_IDX_DIVIDER, 32'h00000004, OK);
        wr(`ESCS_IDX_RANGE, 32'h00000008, OK);
        run(1'b1);
        lfsrState = lfsr(lfsrState);
        gen.burst(16, 200 + int'(lfsrState[5:0]));
        repeat (10) @(posedge clk);
        chk(32'(ticks), 32'h00000004);
        chk({31'h0, useExt}, 32'h00000001);
        wr(`ESCS_IDX_RANGE, 32'h00000020, OK);
        wr(`ESCS_IDX_DIVIDER, 32'h00000002, OK);
        chk({26'h0, rangeSel}, 32'h00000008);
        rd(`ESCS_IDX_STATUS, st(11'h004, 4'h3), OK);
        repeat (250) @(posedge clk);
        rd(`ESCS_IDX_STATUS, st(11'h004, 4'h7), OK);
        run(1'b0);
        run(1'b1);
        chk({26'h0, rangeSel}, 32'h00000020);
        rd(`ESCS_IDX_STATUS, st(11'h002, 4'h3), OK);
        run(1'b0);
        $display("TB: external clock test done");
        wr(`ESCS_IDX_LOWSPEED, 32'h00000001, OK);
        run(1'b1);
        repeat (250) @(posedge clk);
        chk({31'h0, lowSpeedEn}, 32'h00000001);
        rd(`ESCS_IDX_STATUS, st(11'h002, 4'hb), OK);
        gen.burst(6, 250);
        repeat (10) @(posedge clk);
        chk(32'(ticks), 32'h00000003);
        run(1'b0);
        $display("TB: low speed test done");
        test_done();
    end
endmodule : external_sample_clock_select_bench
